// file: hw/spi_emul_pkg.sv
// constants shared by the timer-based spi master emulation
// assumes a 10 MHz system clock and a single slave on the bus
package spi_emul_pkg;
  localparam int unsigned CLOCK_HZ        = 10_000_000;
  // shift paces: data at 1/160, serial clock at 1/80 of system clock
  localparam int unsigned DATA_DIVIDE     = 160;
  localparam int unsigned SCLK_DIVIDE     = 80;
  localparam logic [7:0]  DATA_DIV_LAST   = 8'(DATA_DIVIDE - 1);
  localparam logic [7:0]  SCLK_DIV_LAST   = 8'(SCLK_DIVIDE - 1);
  localparam int unsigned FRAME_BITS      = 8;
  localparam logic [23:0] SCLK_PATTERN    = 24'h005555;
  localparam logic [4:0]  SCLK_SHIFTS     = 5'h10;
  localparam logic [4:0]  DATA_SHIFTS     = 5'h08;
  localparam logic [3:0]  RX_BITS         = 4'h8;
  localparam logic [2:0]  STARTED_TRIGGER = 3'h4;
  localparam logic [2:0]  HOST_TRIGGER    = 3'h1;
  // timebase ticks from request to select fall, and idle after a frame
  localparam logic [15:0] SELECT_DELAY    = 16'h0040;
  localparam logic [15:0] GAP_DELAY       = 16'h00A0;
endpackage : spi_emul_pkg

// file: hw/spi_rx_buffer.sv
// two-entry buffer for received bytes with valid/ready on both sides
// assumes producer and consumer share i_clock
`timescale 1ns/1ns
module spi_rx_buffer (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  // fill side
  input  wire logic       i_in_valid,
  input  wire logic [7:0] i_in_data,
  output logic            o_in_ready,
  // drain side
  output logic            o_out_valid,
  output logic [7:0]      o_out_data,
  input  wire logic       i_out_ready
);
  logic [7:0] slot_reg [2];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;
  logic       rd_next;

  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)  rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) slot_reg[wr_ptr_reg] <= i_in_data;
  end

  // ready and valid are registered copies of the fill level
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      o_in_ready  <= (2'(count_reg + {1'b0, push} - {1'b0, pop})) != 2'h2;
      o_out_valid <= (2'(count_reg + {1'b0, push} - {1'b0, pop})) != 2'h0;
    end
  end

  // head word held in a flop so the data port never shows a slot mux;
  // a word pushed into the slot that becomes head is bypassed straight in
  assign rd_next = rd_ptr_reg ^ pop;

  always_ff @(posedge i_clock) begin
    o_out_data <= (push && wr_ptr_reg == rd_next) ? i_in_data
                  : slot_reg[rd_next];
  end

  a_buffer_no_overflow: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) push |-> count_reg != 2'h2)
    else $error("buffer written while full");
endmodule : spi_rx_buffer

// file: hw/spi_master_timer_emulation.sv
// spi master, mode 0, built like a sequencer driving timer channels
// assumes an 8-bit transmit word from a valid/ready source, a host that
// raises its ready trigger, and an external slave on the serial pins
`timescale 1ns/1ns
module spi_master_timer_emulation
  import spi_emul_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  // host handshake
  input  wire logic       i_sequencer_enable,
  input  wire logic       i_host_trigger,
  output logic [2:0]      o_trigger_state,
  output logic            o_running,
  // transmit words
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  // serial pins
  output logic            o_select_n,
  output logic            o_serial_clock,
  output logic            o_serial_data,
  input  wire logic       i_serial_in,
  input  wire logic       i_serial_clock_in,
  input  wire logic       i_select_in,
  // received bytes
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  input  wire logic       i_rx_ready,
  output logic            o_rx_error
);
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_WAIT    = 6'b000010,
    ST_SELECT  = 6'b000100,
    ST_SHIFT   = 6'b001000,
    ST_TAIL    = 6'b010000,
    ST_GAP     = 6'b100000
  } seq_state_e;

  seq_state_e  state_reg;
  logic [2:0]  trigger_reg;
  logic [15:0] timebase_reg;
  logic [15:0] match_reg;
  logic [7:0]  sclk_div_reg;
  logic [7:0]  data_div_reg;
  logic        sclk_tick;
  logic        data_tick;
  // routed command ports: select level, clock and data shift loads
  logic        sel_cmd_reg;
  logic        sel_route_reg;
  logic        shift_right_reg;
  logic [23:0] sclk_shift_reg;
  logic [23:0] data_shift_reg;
  logic [4:0]  sclk_count_reg;
  logic [4:0]  data_count_reg;
  logic        sclk_busy;
  logic        data_busy;
  logic        load_frame;
  // receive side
  logic [2:0]  sck_sync_reg;
  logic [1:0]  din_sync_reg;
  logic [1:0]  sel_sync_reg;
  logic        edge_event;
  logic [7:0]  rx_acc_reg;
  logic [3:0]  rx_count_reg;
  logic        push_reg;
  logic [7:0]  push_data_reg;
  logic        buf_ready;

  // free-running timebase used for scheduled select changes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) timebase_reg <= 16'h0000;
    else            timebase_reg <= 16'(timebase_reg + 16'h0001);
  end

  // two dividers, restarted together by the sequencer at each frame load;
  // neither channel steps the other
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_div_reg <= 8'h00;
      data_div_reg <= 8'h00;
    end else if (load_frame) begin
      // data leads the first rise, then moves one system clock after each
      // falling clock edge but the last, so the slave never samples a changing bit
      sclk_div_reg <= 8'h00;
      data_div_reg <= DATA_DIV_LAST;
    end else begin
      sclk_div_reg <= (sclk_div_reg == SCLK_DIV_LAST) ? 8'h00
                      : 8'(sclk_div_reg + 8'h01);
      data_div_reg <= (data_div_reg == DATA_DIV_LAST) ? 8'h00
                      : 8'(data_div_reg + 8'h01);
    end
  end
  assign sclk_tick = sclk_div_reg == SCLK_DIV_LAST;
  assign data_tick = data_div_reg == DATA_DIV_LAST;
  assign sclk_busy = sclk_count_reg != 5'h00;
  assign data_busy = data_count_reg != 5'h00;
  assign load_frame = state_reg == ST_SELECT && timebase_reg == match_reg;

  // sequencer: handshake, then endless frame loop
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg   <= ST_IDLE;
      trigger_reg <= 3'h0;
      match_reg   <= 16'h0000;
      sel_cmd_reg <= 1'b1;
      o_tx_ready  <= 1'b0;
    end else begin
      o_tx_ready <= 1'b0;
      unique case (state_reg)
        ST_IDLE: if (i_sequencer_enable) begin
          trigger_reg <= STARTED_TRIGGER;
          state_reg   <= ST_WAIT;
        end
        ST_WAIT: if (i_host_trigger) begin
          trigger_reg <= trigger_reg | HOST_TRIGGER;
          state_reg   <= ST_GAP;
          match_reg   <= 16'(timebase_reg + GAP_DELAY);
        end
        ST_SELECT: if (timebase_reg == match_reg) begin
          sel_cmd_reg <= 1'b0;
          state_reg   <= ST_SHIFT;
        end
        ST_SHIFT: if (!sclk_busy && !data_busy && o_tx_ready == 1'b0
                      && sclk_shift_reg == 24'h0) begin
          match_reg <= 16'(timebase_reg + GAP_DELAY);
          state_reg <= ST_TAIL;
        end
        ST_TAIL: if (timebase_reg == match_reg) begin
          sel_cmd_reg <= 1'b1;
          match_reg   <= 16'(timebase_reg + GAP_DELAY);
          state_reg   <= ST_GAP;
        end
        ST_GAP: if (timebase_reg == match_reg) begin
          if (i_tx_valid) begin
            o_tx_ready <= 1'b1;
            match_reg  <= 16'(timebase_reg + SELECT_DELAY);
            state_reg  <= ST_SELECT;
          end else begin
            // no word yet: keep the match armed rather than wait a wrap
            match_reg <= 16'(timebase_reg + 16'h0001);
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign o_trigger_state = trigger_reg;
  assign o_running = trigger_reg[0];

  // select channel: immediate mode, active level zero, idles high
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_route_reg <= 1'b0;
      o_select_n    <= 1'b1;
    end else begin
      sel_route_reg <= trigger_reg[0];
      o_select_n    <= sel_route_reg ? sel_cmd_reg : 1'b1;
    end
  end

  // serial channels: load routed words when select falls, shift right
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_right_reg <= 1'b0;
      sclk_shift_reg  <= 24'h000000;
      data_shift_reg  <= 24'h000000;
      sclk_count_reg  <= 5'h00;
      data_count_reg  <= 5'h00;
      o_serial_clock  <= 1'b0;
      o_serial_data   <= 1'b0;
    end else begin
      if (load_frame) begin
        shift_right_reg <= 1'b1;
        sclk_shift_reg  <= SCLK_PATTERN;
        sclk_count_reg  <= SCLK_SHIFTS;
        data_count_reg  <= DATA_SHIFTS;
        // bit-reverse so a right shift sends msb first
        for (int b = 0; b < FRAME_BITS; b++) begin
          data_shift_reg[b] <= i_tx_data[FRAME_BITS-1-b];
        end
      end else begin
        // clock pattern bit 0 = 1 rises first; data set before it
        if (sclk_tick && sclk_busy) begin
          o_serial_clock <= shift_right_reg ? sclk_shift_reg[0]
                            : sclk_shift_reg[23];
          sclk_shift_reg <= shift_right_reg ? {1'b0, sclk_shift_reg[23:1]}
                            : {sclk_shift_reg[22:0], 1'b0};
          sclk_count_reg <= 5'(sclk_count_reg - 5'h01);
        end else if (!sclk_busy) begin
          o_serial_clock <= 1'b0;
          sclk_shift_reg <= 24'h000000;
        end
        if (data_tick && data_busy) begin
          o_serial_data  <= data_shift_reg[0];
          data_shift_reg <= {1'b0, data_shift_reg[23:1]};
          data_count_reg <= 5'(data_count_reg - 5'h01);
        end
      end
    end
  end

  // pins from outside pass two flops; third stage feeds edge detect
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_sync_reg <= 3'h0;
      din_sync_reg <= 2'h0;
      sel_sync_reg <= 2'h3;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], i_serial_clock_in};
      din_sync_reg <= {din_sync_reg[0], i_serial_in};
      sel_sync_reg <= {sel_sync_reg[0], i_select_in};
    end
  end
  assign edge_event = sck_sync_reg[1] && !sck_sync_reg[2];

  // receive accumulator, msb first, byte pushed after eight edges
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_acc_reg    <= 8'h00;
      rx_count_reg  <= 4'h0;
      push_reg      <= 1'b0;
      push_data_reg <= 8'h00;
      o_rx_error    <= 1'b0;
    end else begin
      if (push_reg && buf_ready) push_reg <= 1'b0;
      if (edge_event) begin
        o_rx_error <= sel_sync_reg[1];
        if (4'(rx_count_reg + 4'h1) == RX_BITS) begin
          push_data_reg <= {rx_acc_reg[6:0], din_sync_reg[1]};
          push_reg      <= 1'b1;
          rx_acc_reg    <= 8'h00;
          rx_count_reg  <= 4'h0;
        end else begin
          rx_acc_reg   <= {rx_acc_reg[6:0], din_sync_reg[1]};
          rx_count_reg <= 4'(rx_count_reg + 4'h1);
        end
      end
    end
  end

  spi_rx_buffer u_rx_buffer (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (push_reg),
    .i_in_data   (push_data_reg),
    .o_in_ready  (buf_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );

  a_select_idle_high: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) !o_running |=> o_select_n)
    else $error("select low before handshake");
  a_clock_idle_low: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) state_reg == ST_GAP |-> !o_serial_clock)
    else $error("serial clock high while idle");
  a_handshake_wait: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) state_reg == ST_WAIT |-> trigger_reg[2])
    else $error("start trigger missing");
  a_select_at_match: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    (state_reg == ST_SELECT && timebase_reg == match_reg)
    |=> ##1 !o_select_n)
    else $error("select not low after match");
  a_select_released: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    (state_reg == ST_TAIL && timebase_reg == match_reg) |=> ##1 o_select_n)
    else $error("select not released after frame");
  a_clock_count: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) sclk_count_reg <= SCLK_SHIFTS)
    else $error("clock shift count out of range");
  a_data_pace: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    $changed(data_count_reg) && data_count_reg != DATA_SHIFTS
    |-> data_div_reg == 8'h00)
    else $error("data shifted off its divider tick");
  a_data_low_clock: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) $changed(o_serial_data) |-> !o_serial_clock)
    else $error("serial data changed while clock high");
  a_rx_count_bound: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) rx_count_reg < RX_BITS)
    else $error("receive bit counter overran");
endmodule : spi_master_timer_emulation

// file: verification/spi_slave_model.sv
// behavioural spi slave for the emulated master: mode 0, msb first
// assumes the master's select, serial clock and data pins wired straight in
`timescale 1ns/1ns
module spi_slave_model (
  // master pins
  input  wire logic        i_select_n,
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  // reply byte, return line and observations
  input  wire logic [7:0]  i_reply,
  output logic             o_miso,
  output logic [7:0]       o_got,
  output logic [3:0]       o_edges,
  output logic [15:0]      o_frames
);
  logic [7:0] shift_reg;
  initial begin
    o_miso = 1'b0;
    o_got = 8'h00;
    o_edges = 4'h0;
    o_frames = 16'h0000;
    shift_reg = 8'h00;
  end
  // low select opens the frame; first bit must be on the line at once
  always @(negedge i_select_n) begin
    shift_reg = i_reply;
    o_miso = i_reply[7];
    o_got = 8'h00;
    o_edges = 4'h0;
  end
  always @(posedge i_sclk) begin
    if (!i_select_n) begin
      o_got = {o_got[6:0], i_mosi};
      o_edges = o_edges + 4'h1;
    end
  end
  always @(negedge i_sclk) begin
    if (!i_select_n) begin
      shift_reg = {shift_reg[6:0], 1'b0};
      o_miso = shift_reg[7];
    end
  end
  // released line: show the inverse so a stale bit is never trusted
  always @(posedge i_select_n) begin
    o_miso = ~o_miso;
    o_frames = o_frames + 16'h0001;
  end
endmodule : spi_slave_model

// file: verification/tb.sv
// self-checking bench for the spi master emulation with a slave model
// assumes the serial clock and select pins are looped back to the inputs
`timescale 1ns/1ns
module tb;
  import spi_emul_pkg::*;
  logic        i_clock, i_reset_n, i_sequencer_enable, i_host_trigger;
  logic        i_tx_valid, i_rx_ready, sel_break, miso;
  logic        o_running, o_tx_ready, o_select_n, o_serial_clock;
  logic        o_serial_data, o_rx_valid, o_rx_error, bad;
  logic [2:0]  o_trigger_state;
  logic [7:0]  i_tx_data, reply, o_rx_data, got;
  logic [3:0]  edges;
  logic [15:0] frames;
  int          fails, n_checks, k;
  int          rxq[$];

  spi_master_timer_emulation uut (
    .i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_sequencer_enable(i_sequencer_enable),
    .i_host_trigger(i_host_trigger), .o_trigger_state(o_trigger_state),
    .o_running(o_running), .i_tx_valid(i_tx_valid),
    .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
    .o_select_n(o_select_n), .o_serial_clock(o_serial_clock),
    .o_serial_data(o_serial_data), .i_serial_in(miso),
    .i_serial_clock_in(o_serial_clock),
    .i_select_in(o_select_n | sel_break), .o_rx_valid(o_rx_valid),
    .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready),
    .o_rx_error(o_rx_error));

  spi_slave_model slave (
    .i_select_n(o_select_n), .i_sclk(o_serial_clock),
    .i_mosi(o_serial_data), .i_reply(reply), .o_miso(miso),
    .o_got(got), .o_edges(edges), .o_frames(frames));

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task check(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  task step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : step

  // bounded wait for a select level; running out ends the run
  task wait_sel(input logic lvl);
    k = 0;
    while (o_select_n !== lvl && k < 4000) begin
      step(1);
      k++;
    end
    if (k >= 4000) begin
      check(0, "select wait timed out");
      final_report();
    end
  endtask : wait_sel

  task frame(input logic brk);
    logic [7:0] tx;
    tx = 8'($urandom);
    reply = 8'($urandom);
    rxq.push_back(int'(reply));
    sel_break = brk;
    i_tx_data = tx;
    i_tx_valid = 1'b1;
    k = 0;
    while (o_tx_ready !== 1'b1 && k < 2000) begin
      step(1);
      k++;
    end
    check(k < 2000, "transmit word not taken");
    if (k >= 2000) final_report();
    step(1);
    i_tx_valid = 1'b0;
    wait_sel(1'b0);
    wait_sel(1'b1);
    step(2);
    check(got === tx, "slave saw wrong byte");
    check(edges === 4'h8, "clock pulse count");
    check(o_serial_clock === 1'b0, "clock not idle low");
    check(o_rx_error === brk, "select error flag");
    sel_break = 1'b0;
  endtask : frame

  // receive stream compared with the model queue at every transfer;
  // looked at mid-cycle, where valid, ready and data are settled
  always @(negedge i_clock) begin
    if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) begin
      if (rxq.size() == 0) check(0, "unexpected received byte");
      else check(o_rx_data === 8'(rxq.pop_front()), "rx byte");
    end
  end

  initial begin
    void'($urandom(32'hFC69));
    {i_reset_n, i_sequencer_enable, i_host_trigger} = 3'h0;
    {i_tx_valid, i_rx_ready, sel_break} = 3'h0;
    i_tx_data = 8'h00;
    reply = 8'h00;
    repeat (8) @(posedge i_clock);
    check(o_select_n === 1'b1 && o_serial_clock === 1'b0, "reset pins");
    check(o_trigger_state === 3'h0 && o_rx_valid === 1'b0, "reset");
    #1 i_reset_n = 1'b1;
    // early host trigger and an offered word before start-up: refused
    i_host_trigger = 1'b1;
    i_tx_valid = 1'b1;
    bad = 1'b0;
    for (int n = 0; n < 300; n++) begin
      step(1);
      if (o_select_n !== 1'b1 || o_tx_ready !== 1'b0) bad = 1'b1;
    end
    check(!bad, "frame before handshake");
    check(o_trigger_state === 3'h0, "early trigger taken");
    {i_host_trigger, i_tx_valid} = 2'h0;
    i_sequencer_enable = 1'b1;
    step(2);
    check(o_trigger_state === STARTED_TRIGGER, "started trigger");
    i_host_trigger = 1'b1;
    step(2);
    check(o_trigger_state === (STARTED_TRIGGER | HOST_TRIGGER), "host");
    check(o_running === 1'b1, "not running");
    i_host_trigger = 1'b0;
    $display("test handshake done");
    i_rx_ready = 1'b1;
    for (int n = 0; n < 3; n++) frame(1'b0);
    $display("test back to back frames done");
    frame(1'b1);
    frame(1'b0);
    $display("test select error done");
    i_rx_ready = 1'b0;
    frame(1'b0);
    frame(1'b0);
    check(o_rx_valid === 1'b1, "stalled byte lost");
    i_rx_ready = 1'b1;
    step(12);
    check(rxq.size() == 0, "bytes left undelivered");
    $display("test receiver stall done");
    final_report();
  end
endmodule : tb
